// ---- pkg/strap_cfg_regs.vh ----
// Constants for the startup strap configuration decoder
`ifndef STRAP_CFG_REGS_VH
`define STRAP_CFG_REGS_VH

// Register byte offsets on the Avalon-MM slave
`define REG_STRAP_RAW      4'h0
`define REG_SENS_CFG       4'h4
`define REG_SERIAL_CFG     4'h8
`define REG_MISC_CFG       4'hC

// Sensitivity mode codes
`define SENS_AUTO          2'h0
`define SENS_FAST          2'h1
`define SENS_NORMAL        2'h2
`define SENS_HIGH          2'h3

// Protocol codes
`define PROTO_NONE         2'h0
`define PROTO_NMEA         2'h1
`define PROTO_BIN          2'h2

// Baud codes
`define BAUD_AUTO          3'h0
`define BAUD_4K8           3'h1
`define BAUD_9K6           3'h2
`define BAUD_19K2          3'h3
`define BAUD_38K4          3'h4
`define BAUD_57K6          3'h5
`define BAUD_115K2         3'h6

// Message level codes
`define MSG_OFF            3'h0
`define MSG_LOW            3'h1
`define MSG_MEDIUM         3'h2
`define MSG_HIGH           3'h3
`define MSG_DEBUG          3'h4

// Information class masks: bit0 user, bit1 notice, bit2 warning, bit3 error, bit4 other
`define INF_NONE           5'h00
`define INF_STD            5'h0F
`define INF_ALL            5'h1F

// Integration time codes, auto is adaptive
`define INTEG_ADAPTIVE     2'h0
`define INTEG_SHORT        2'h1
`define INTEG_MEDIUM       2'h2
`define INTEG_LONG         2'h3

// Internal pull levels of straps at reset, bit i = strap i
`define STRAP_PULL_RESET   13'h1DCE

// Settle time after reset release before sampling
`define SETTLE_NS          1000
`define CLK_PERIOD_NS      20
`define SETTLE_CYCLES      ((`SETTLE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// ---- core/strap_sync.v ----
// Two-flop synchroniser bank for the strap and detection pins
module strap_sync #(
   parameter WIDTH = 13
) (
   input  wire             ref_clk,
   input  wire             rst_n,
   input  wire [WIDTH-1:0] async_in,
   input  wire [WIDTH-1:0] reset_level,
   output wire [WIDTH-1:0] sync_out
);
   reg [WIDTH-1:0] meta_r;   // First stage, read only by second stage
   reg [WIDTH-1:0] sync_r;   // Second stage

   genvar i;
   // One synchroniser per bit; flops hold the offset from the idle level,
   // so a plain zero reset still shows the idle level at the output
   generate
      for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
         always @(posedge ref_clk or negedge rst_n) begin
            if (!rst_n) begin
               meta_r[i] <= 1'b0;
               sync_r[i] <= 1'b0;
            end else begin
               meta_r[i] <= async_in[i] ^ reset_level[i];
               sync_r[i] <= meta_r[i];
            end
         end
      end
   endgenerate

   // Restore the pin level; during reset this is the idle level
   assign sync_out = sync_r ^ reset_level;
endmodule // strap_sync

// ---- core/strap_config_decoder.v ----
// Startup strap configuration decoder with Avalon-MM register access
//
// Contract
// - Startup settings come from straps after reset
// - Enable low: ignore straps, use defaults
// - Enable high: decode straps 2,3,5-8,10-12
// - Open straps decode at internal pull level
// - Straps 3,2 select auto/fast/normal/high
// - Fixed modes fixed integration; auto adaptive
// - Sensitivity affects acquisition only, not tracking
// - Protocol enable per port, then messages
// - All inputs enabled; one output protocol
// - Strap12=0: straps 6,5 pick table A
// - Strap12=1: straps 6,5 pick table B
// - Info classes standard; debug all; auto none
// - Straps 1,4,9 not decoded; antenna inputs
// - Commands may replace strap configuration later
// - Boot mode and straps stay GPIO
// - Antenna, memory, sleep, shutdown, selects active-low
// - USB power strap: 0 bus 100mA, 1 self
// - Defaults: NMEA 57.6, binary 57.6, USB NMEA
// - Straps 11,10 pick antenna detect pin
//
// Local design decisions: register access over Avalon-MM and the address map.
`include "strap_cfg_regs.vh"

module strap_config_decoder #(
   parameter SETTLE_CYCLES = `SETTLE_CYCLES
) (
   input  wire        ref_clk,
   input  wire        rst_n,
   input  wire [12:0] config_straps,
   input  wire        antenna_present0_n,
   input  wire        antenna_present1_n,
   input  wire        antenna_short_n,
   input  wire        ext_mem_enable_n,
   input  wire        boot_mode,
   input  wire        debug_enable,
   input  wire [3:0]  avs_address,
   input  wire        avs_read,
   input  wire        avs_write,
   input  wire [31:0] avs_writedata,
   output reg  [31:0] avs_readdata,
   output reg         avs_waitrequest,
   output reg         config_valid,
   output reg  [1:0]  sens_mode,
   output reg  [1:0]  integ_time,
   output reg  [1:0]  port1_proto,
   output reg  [2:0]  port1_baud,
   output reg  [1:0]  port2_proto,
   output reg  [2:0]  port2_baud,
   output reg  [1:0]  usb_proto,
   output reg  [2:0]  msg_level,
   output reg  [4:0]  info_classes,
   output reg  [2:0]  proto_in_en,
   output reg         usb_self_powered,
   output reg         antenna_det_sel,
   output reg         antenna_present,
   output reg         antenna_short,
   output reg         ext_mem_enable,
   output reg         sleep_out_n,
   output reg         shutdown_out_n,
   output reg  [3:0]  periph_select_n,
   output reg         gpio_owns_pins,
   output reg         debug_active
);
   // Sampling state machine codes
   localparam ST_SETTLE = 2'h0;
   localparam ST_SAMPLE = 2'h1;
   localparam ST_HOLD   = 2'h2;
   localparam [31:0] SETTLE_LAST = SETTLE_CYCLES - 1; // Last settle count before sampling

   wire [12:0] straps_s;          // Synchronised straps
   wire [5:0]  misc_s;            // Synchronised detect, boot and debug pins
   reg  [1:0]  state_r;           // Sampling state
   reg  [1:0]  state_nxt;
   reg  [15:0] settle_cnt_r;      // Settle counter
   reg  [12:0] strap_raw_r;       // Latched strap snapshot
   reg         sw_override_r;     // Software replaced the strap serial setup
   reg         bus_ack_r;         // Second cycle of an access

   // Decoded values from latched straps
   reg [1:0] d_sens;
   reg [1:0] d_integ;
   reg [1:0] d_p1_proto;
   reg [2:0] d_p1_baud;
   reg [1:0] d_p2_proto;
   reg [2:0] d_p2_baud;
   reg [2:0] d_level;
   reg [4:0] d_info;
   reg       d_self_pwr;
   reg       d_ant_sel;

   // Straps and detect pins come from the board, synchronise first
   // Idle levels: detect pins high, boot and debug low, so no false event after reset
   strap_sync #(
      .WIDTH (19)
   ) u_sync (
      .ref_clk     (ref_clk),
      .rst_n       (rst_n),
      .async_in    ({debug_enable, boot_mode, ext_mem_enable_n, antenna_short_n, antenna_present1_n,
                     antenna_present0_n, config_straps}),
      .reset_level ({2'b00, 4'hF, `STRAP_PULL_RESET}),
      .sync_out    ({misc_s, straps_s})
   );

   // Next state of the sampling sequence
   always @* begin
      state_nxt = state_r;
      case (state_r)
         ST_SETTLE: begin
            if (settle_cnt_r >= SETTLE_LAST[15:0]) begin
               state_nxt = ST_SAMPLE;
            end
         end
         ST_SAMPLE: begin
            state_nxt = ST_HOLD;
         end
         ST_HOLD: begin
            state_nxt = ST_HOLD;
         end
         default: begin
            state_nxt = ST_SETTLE;
         end
      endcase
   end

   // Wait for synchronisers and board to settle, then latch once
   always @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         state_r      <= ST_SETTLE;
         settle_cnt_r <= 16'h0000;
         strap_raw_r  <= `STRAP_PULL_RESET;
      end else begin
         state_r <= state_nxt;
         if (state_r == ST_SETTLE) begin
            settle_cnt_r <= settle_cnt_r + 16'h0001;
         end
         if (state_r == ST_SAMPLE) begin
            strap_raw_r <= straps_s;
         end
      end
   end

   // Decode the latched straps
   always @* begin
      d_self_pwr = 1'b1;
      d_ant_sel  = 1'b1;
      d_sens     = `SENS_AUTO;
      d_p1_proto = `PROTO_NMEA;
      d_p1_baud  = `BAUD_57K6;
      d_p2_proto = `PROTO_BIN;
      d_p2_baud  = `BAUD_57K6;
      d_level    = `MSG_MEDIUM;
      d_info     = `INF_STD;
      if (strap_raw_r[0]) begin
         // Straps 1, 4 and 9 never take part here
         d_sens     = {strap_raw_r[3], strap_raw_r[2]};
         d_self_pwr = strap_raw_r[7];
         // Reserved combinations fall to pin 4 as listed
         case ({strap_raw_r[11], strap_raw_r[10], strap_raw_r[8]})
            3'b000, 3'b001, 3'b110, 3'b111: d_ant_sel = 1'b0;
            default: d_ant_sel = 1'b1;
         endcase
         case ({strap_raw_r[12], strap_raw_r[6], strap_raw_r[5]})
            3'b000: begin
               d_p1_proto = `PROTO_BIN;
               d_p1_baud  = `BAUD_57K6;
               d_p2_proto = `PROTO_NMEA;
               d_p2_baud  = `BAUD_19K2;
               d_level    = `MSG_HIGH;
            end
            3'b001: begin
               d_p1_proto = `PROTO_BIN;
               d_p1_baud  = `BAUD_38K4;
               d_p2_proto = `PROTO_NMEA;
               d_p2_baud  = `BAUD_9K6;
               d_level    = `MSG_MEDIUM;
            end
            3'b010: begin
               d_p1_proto = `PROTO_BIN;
               d_p1_baud  = `BAUD_19K2;
               d_p2_proto = `PROTO_NMEA;
               d_p2_baud  = `BAUD_4K8;
               d_level    = `MSG_LOW;
            end
            3'b011: begin
               d_p1_proto = `PROTO_NONE;
               d_p1_baud  = `BAUD_AUTO;
               d_p2_proto = `PROTO_NONE;
               d_p2_baud  = `BAUD_AUTO;
               d_level    = `MSG_OFF;
               d_info     = `INF_NONE;
            end
            3'b100: begin
               d_p1_proto = `PROTO_NMEA;
               d_p1_baud  = `BAUD_19K2;
               d_p2_proto = `PROTO_BIN;
               d_p2_baud  = `BAUD_57K6;
               d_level    = `MSG_HIGH;
            end
            3'b101: begin
               d_p1_proto = `PROTO_NMEA;
               d_p1_baud  = `BAUD_4K8;
               d_p2_proto = `PROTO_BIN;
               d_p2_baud  = `BAUD_19K2;
               d_level    = `MSG_LOW;
            end
            3'b110: begin
               d_p1_proto = `PROTO_NMEA;
               d_p1_baud  = `BAUD_9K6;
               d_p2_proto = `PROTO_BIN;
               d_p2_baud  = `BAUD_38K4;
               d_level    = `MSG_MEDIUM;
            end
            default: begin
               d_p1_proto = `PROTO_BIN;
               d_p1_baud  = `BAUD_115K2;
               d_p2_proto = `PROTO_NMEA;
               d_p2_baud  = `BAUD_19K2;
               d_level    = `MSG_DEBUG;
               d_info     = `INF_ALL;
            end
         endcase
      end
      // Integration time follows sensitivity only; tracking is untouched
      case (d_sens)
         `SENS_FAST:   d_integ = `INTEG_SHORT;
         `SENS_NORMAL: d_integ = `INTEG_MEDIUM;
         `SENS_HIGH:   d_integ = `INTEG_LONG;
         default:      d_integ = `INTEG_ADAPTIVE;
      endcase
   end

   // Output registers, with software override of serial setup
   always @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         config_valid     <= 1'b0;
         sens_mode        <= `SENS_AUTO;
         integ_time       <= `INTEG_ADAPTIVE;
         port1_proto      <= `PROTO_NMEA;
         port1_baud       <= `BAUD_57K6;
         port2_proto      <= `PROTO_BIN;
         port2_baud       <= `BAUD_57K6;
         usb_proto        <= `PROTO_NMEA;
         msg_level        <= `MSG_MEDIUM;
         info_classes     <= `INF_STD;
         proto_in_en      <= 3'h7;
         usb_self_powered <= 1'b1;
         antenna_det_sel  <= 1'b1;
         antenna_present  <= 1'b0;
         antenna_short    <= 1'b0;
         ext_mem_enable   <= 1'b0;
         sleep_out_n      <= 1'b1;
         shutdown_out_n   <= 1'b1;
         periph_select_n  <= 4'hF;
         gpio_owns_pins   <= 1'b1;
         debug_active     <= 1'b0;
         sw_override_r    <= 1'b0;
      end else begin
         gpio_owns_pins <= 1'b1;
         debug_active   <= misc_s[5];
         proto_in_en    <= 3'h7;
         usb_proto      <= `PROTO_NMEA;
         // Active-low pins are inverted into positive flags
         antenna_present <= antenna_det_sel ? ~misc_s[1] : ~misc_s[0];
         antenna_short   <= ~misc_s[2];
         ext_mem_enable  <= ~misc_s[3];
         if (state_r == ST_HOLD) begin
            config_valid     <= 1'b1;
            sens_mode        <= d_sens;
            integ_time       <= d_integ;
            usb_self_powered <= d_self_pwr;
            antenna_det_sel  <= d_ant_sel;
            if (!sw_override_r) begin
               port1_proto  <= d_p1_proto;
               port1_baud   <= d_p1_baud;
               port2_proto  <= d_p2_proto;
               port2_baud   <= d_p2_baud;
               msg_level    <= d_level;
               info_classes <= d_info;
            end
         end
         // Command write replaces serial setup
         if (avs_write && bus_ack_r && avs_address == `REG_SERIAL_CFG) begin
            sw_override_r <= 1'b1;
            port1_proto   <= avs_writedata[1:0];
            port1_baud    <= avs_writedata[4:2];
            port2_proto   <= avs_writedata[6:5];
            port2_baud    <= avs_writedata[9:7];
            msg_level     <= avs_writedata[12:10];
            info_classes  <= avs_writedata[17:13];
         end
      end
   end

   // Avalon slave: one wait cycle, answer on the second cycle
   always @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         bus_ack_r       <= 1'b0;
         avs_waitrequest <= 1'b1;
         avs_readdata    <= 32'h00000000;
      end else begin
         if ((avs_read || avs_write) && !bus_ack_r) begin
            bus_ack_r       <= 1'b1;
            avs_waitrequest <= 1'b0;
            case (avs_address)
               `REG_STRAP_RAW:  avs_readdata <= {19'h00000, strap_raw_r};
               `REG_SENS_CFG:   avs_readdata <= {27'h0000000, config_valid, integ_time, sens_mode};
               `REG_SERIAL_CFG: avs_readdata <= {14'h0000, info_classes, msg_level,
                                                port2_baud, port2_proto, port1_baud, port1_proto};
               `REG_MISC_CFG:   avs_readdata <= {25'h0000000, sw_override_r, ext_mem_enable,
                                                antenna_short, antenna_present, antenna_det_sel,
                                                usb_self_powered, misc_s[4]};
               default:         avs_readdata <= 32'h00000000;
            endcase
         end else begin
            bus_ack_r       <= 1'b0;
            avs_waitrequest <= 1'b1;
         end
      end
   end
endmodule // strap_config_decoder

// ---- testbench/strap_board.sv ----
// Board model: tied straps and open straps resting at their internal pull
`include "strap_cfg_regs.vh"
module strap_board (
   input  wire logic [12:0] drive_val,    // Level of each tied strap
   input  wire logic [12:0] tie_mask,     // One where the board ties the strap
   output wire logic [12:0] config_straps // Level seen at the strap pins
);
   timeunit 1ns;
   timeprecision 1ps;
   // Open pins show the pull level, tied pins their tie, steady while driven
   assign config_straps = (drive_val & tie_mask) | (`STRAP_PULL_RESET & ~tie_mask);
endmodule // strap_board

// ---- testbench/strap_config_checker.sv ----
// Port-level assertions for the strap decoder
module strap_config_checker (
   input wire        ref_clk,
   input wire        rst_n,
   input wire [3:0]  avs_address,
   input wire        avs_read,
   input wire        avs_write,
   input wire [31:0] avs_readdata,
   input wire        avs_waitrequest,
   input wire        config_valid,
   input wire [1:0]  sens_mode,
   input wire [1:0]  integ_time,
   input wire [2:0]  msg_level,
   input wire [4:0]  info_classes,
   input wire [2:0]  proto_in_en,
   input wire        usb_self_powered,
   input wire        antenna_det_sel,
   input wire        antenna_short_n,
   input wire        antenna_short,
   input wire        ext_mem_enable_n,
   input wire        ext_mem_enable,
   input wire        sleep_out_n,
   input wire        shutdown_out_n,
   input wire [3:0]  periph_select_n,
   input wire        gpio_owns_pins
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_n);
   // Request still waiting, then a one-cycle acknowledge
   sequence s_req; (avs_read || avs_write) && avs_waitrequest; endsequence
   sequence s_ack; !avs_waitrequest ##1 avs_waitrequest; endsequence
   a_bus_answer: assert property (s_req |=> s_ack) else $error("bus answer late or long");
   a_unmapped_zero: assert property (avs_read && avs_waitrequest && avs_address[1:0] != 2'h0
      |=> avs_readdata == 32'h0) else $error("unmapped read not zero");
   a_sens_readback: assert property (avs_read && !avs_waitrequest && avs_address == 4'h4
      |-> avs_readdata == {27'h0, config_valid, integ_time, sens_mode}) else $error("sens reg wrong");
   a_integ_fixed: assert property (config_valid |-> integ_time == sens_mode) else $error("integ wrong");
   a_pins_idle: assert property (proto_in_en == 3'h7 && sleep_out_n && shutdown_out_n
      && periph_select_n == 4'hF && gpio_owns_pins) else $error("idle pins wrong");
   a_config_hold: assert property (config_valid && $past(config_valid) |-> $stable(sens_mode)
      && $stable(usb_self_powered) && $stable(antenna_det_sel)) else $error("config moved");
   a_valid_sticks: assert property (config_valid |=> config_valid) else $error("valid dropped");
   a_short_low: assert property ($fell(antenna_short_n) |-> ##[1:4] antenna_short)
      else $error("short not seen");
   a_extmem_low: assert property ($fell(ext_mem_enable_n) |-> ##[1:4] ext_mem_enable)
      else $error("memory enable not seen");
   a_info_class: assert property (config_valid |-> info_classes == (msg_level == 3'h4 ? 5'h1F :
      msg_level == 3'h0 ? 5'h00 : 5'h0F)) else $error("info classes wrong");
endmodule // strap_config_checker

bind strap_config_decoder strap_config_checker chk (.ref_clk, .rst_n, .avs_address, .avs_read, .avs_write,
   .avs_readdata, .avs_waitrequest, .config_valid, .sens_mode, .integ_time, .msg_level, .info_classes,
   .proto_in_en, .usb_self_powered, .antenna_det_sel, .antenna_short_n, .antenna_short, .ext_mem_enable_n,
   .ext_mem_enable, .sleep_out_n, .shutdown_out_n, .periph_select_n, .gpio_owns_pins);

// ---- testbench/startup_strap_config_decoder_test.sv ----
// Self-checking bench for the strap decoder
`include "strap_cfg_regs.vh"
module startup_strap_config_decoder_test;
   timeunit 1ns;
   timeprecision 1ps;
   logic        ref_clk = 0, rst_n = 0, ap0_n = 1, ap1_n = 1, short_n = 1, ext_n = 1, boot = 0, dbg = 0;
   logic [12:0] drv = 0, tie = 0;        // Board tie levels and mask
   logic [12:0] config_straps;           // Pins seen by the design
   logic [3:0]  avs_address = 0;         // Bus request
   logic        avs_read = 0, avs_write = 0;
   logic [31:0] avs_writedata = 0, avs_readdata, rd;
   logic        avs_waitrequest, config_valid, usb_self_powered, antenna_det_sel, antenna_present;
   logic        antenna_short, ext_mem_enable, sleep_out_n, shutdown_out_n, gpio_owns_pins, debug_active;
   logic [1:0]  sens_mode, integ_time, port1_proto, port2_proto, usb_proto;
   logic [2:0]  port1_baud, port2_baud, msg_level, proto_in_en;
   logic [4:0]  info_classes;
   logic [3:0]  periph_select_n;
   logic [23:0] exp;                     // Expected decode
   logic [12:0] v, eff;
   int          err_count = 0, compares = 0, seed, tn = 0, r, i;

   strap_board board (.drive_val(drv), .tie_mask(tie), .config_straps(config_straps));
   strap_config_decoder #(.SETTLE_CYCLES(4)) DUT (
      .ref_clk(ref_clk), .rst_n(rst_n), .config_straps(config_straps), .antenna_present0_n(ap0_n),
      .antenna_present1_n(ap1_n), .antenna_short_n(short_n), .ext_mem_enable_n(ext_n), .boot_mode(boot),
      .debug_enable(dbg), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
      .avs_writedata(avs_writedata), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
      .config_valid(config_valid), .sens_mode(sens_mode), .integ_time(integ_time), .port1_proto(port1_proto),
      .port1_baud(port1_baud), .port2_proto(port2_proto), .port2_baud(port2_baud), .usb_proto(usb_proto),
      .msg_level(msg_level), .info_classes(info_classes), .proto_in_en(proto_in_en),
      .usb_self_powered(usb_self_powered), .antenna_det_sel(antenna_det_sel), .antenna_present(antenna_present),
      .antenna_short(antenna_short), .ext_mem_enable(ext_mem_enable), .sleep_out_n(sleep_out_n),
      .shutdown_out_n(shutdown_out_n), .periph_select_n(periph_select_n), .gpio_owns_pins(gpio_owns_pins),
      .debug_active(debug_active));

   // Free-running clock
   initial begin
      forever #10 ref_clk = ~ref_clk;
   end

   // Reference decode: {sens, integ, serial fields, self powered, detect select}
   function automatic logic [23:0] model(input logic [12:0] s);
      logic [17:0] ser;
      logic        dsel;
      case ({s[12], s[6], s[5]})
         3'h0: ser = {5'h0F, 3'h3, 3'h3, 2'h1, 3'h5, 2'h2};
         3'h1: ser = {5'h0F, 3'h2, 3'h2, 2'h1, 3'h4, 2'h2};
         3'h2: ser = {5'h0F, 3'h1, 3'h1, 2'h1, 3'h3, 2'h2};
         3'h3: ser = {5'h00, 3'h0, 3'h0, 2'h0, 3'h0, 2'h0};
         3'h4: ser = {5'h0F, 3'h3, 3'h5, 2'h2, 3'h3, 2'h1};
         3'h5: ser = {5'h0F, 3'h1, 3'h3, 2'h2, 3'h1, 2'h1};
         3'h6: ser = {5'h0F, 3'h2, 3'h4, 2'h2, 3'h2, 2'h1};
         default: ser = {5'h1F, 3'h4, 3'h3, 2'h1, 3'h6, 2'h2};
      endcase
      dsel = !({s[11], s[10], s[8]} inside {3'h0, 3'h1, 3'h6, 3'h7});
      if (!s[0]) return {4'h0, 5'h0F, 3'h2, 3'h5, 2'h2, 3'h5, 2'h1, 2'h3};
      return {s[3], s[2], s[3], s[2], ser, s[7], dsel};
   endfunction

   task automatic give_verdict();
      $display("compares %0d mismatches %0d", compares, err_count);
      if (err_count == 0 && compares > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask

   task automatic check(input logic [31:0] seen, input logic [31:0] want, input string what);
      compares++;
      if (seen !== want) begin
         err_count++;
         $display("[FAIL] %0t %s seen %h want %h", $time, what, seen, want);
      end
   endtask

   // One Avalon access, held until waitrequest is sampled low
   task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] wd);
      int n;
      avs_address <= a;
      avs_writedata <= wd;
      avs_read <= !wr;
      avs_write <= wr;
      n = 0;
      do begin
         @(posedge ref_clk);
         n++;
      end while (avs_waitrequest !== 1'b0 && n < 50);
      rd = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      if (n >= 50) begin
         err_count++;
         give_verdict();
      end
      @(posedge ref_clk);
   endtask

   // Reset with a board setup, then wait for the latched decode
   task automatic start(input logic [12:0] val, input logic [12:0] m);
      int n;
      drv <= val;
      tie <= m;
      rst_n <= 1'b0;
      repeat (20) @(posedge ref_clk);
      rst_n <= 1'b1;
      n = 0;
      do begin
         @(posedge ref_clk);
         n++;
      end while (config_valid !== 1'b1 && n < 100);
      if (n >= 100) begin
         err_count++;
         give_verdict();
      end
      eff = (val & m) | (`STRAP_PULL_RESET & ~m);
      exp = model(eff);
   endtask

   // Decode, registers, hold after sampling, and pin polarity
   task automatic run_checks();
      repeat (2) begin
         check({sens_mode, integ_time, info_classes, msg_level, port2_baud, port2_proto, port1_baud, port1_proto,
            usb_self_powered, antenna_det_sel}, exp, "decode");
         bus(1'b0, 4'h0, 32'h0);
         check(rd, {19'h0, eff}, "raw straps");
         bus(1'b0, 4'h8, 32'h0);
         check(rd, {14'h0, exp[19:2]}, "serial reg");
         bus(1'b0, 4'h4, 32'h0);
         check(rd, {28'h1, exp[21:20], exp[23:22]}, "sens reg");
         r = $random(seed);
         drv <= ~drv;
         {ap0_n, ap1_n, short_n, ext_n, boot, dbg} <= r[5:0];
         repeat (8) @(posedge ref_clk);
      end
      drv <= ~drv;
      check({antenna_present, antenna_short, ext_mem_enable, debug_active},
         {!(exp[0] ? ap1_n : ap0_n), !short_n, !ext_n, dbg}, "pins");
      bus(1'b0, 4'h3, 32'h0);
      check(rd, 32'h0, "unmapped");
      bus(1'b0, 4'hC, 32'h0);
      check(rd, {25'h0, 1'b0, !ext_n, !short_n, !(exp[0] ? ap1_n : ap0_n), exp[0], exp[1], boot}, "misc reg");
      tn++;
      $display("test %0d done", tn);
   endtask

   initial begin
      seed = 12;
      for (i = 0; i < 8; i++) begin
         r = $random(seed);
         v = r[12:0];
         v[0] = 1'b1;
         {v[12], v[6], v[5]} = i[2:0];
         {v[3], v[2]} = i[1:0];
         {v[11], v[10], v[8]} = i[2:0];
         start(v, 13'h1FFF);
         run_checks();
      end
      r = $random(seed);
      start(r[12:0] & 13'h1FFE, 13'h1FFF);
      check(usb_proto, `PROTO_NMEA, "usb default");
      run_checks();
      start(13'h0001, 13'h0001);
      run_checks();
      bus(1'b1, 4'h8, {14'h0, 5'h1F, 3'h4, 3'h6, 2'h1, 3'h6, 2'h2});
      bus(1'b1, 4'h0, 32'h0);
      bus(1'b0, 4'h8, 32'h0);
      check(rd, {14'h0, 5'h1F, 3'h4, 3'h6, 2'h1, 3'h6, 2'h2}, "override");
      check(port1_baud, `BAUD_115K2, "override out");
      bus(1'b0, 4'h0, 32'h0);
      check(rd, {19'h0, eff}, "raw read only");
      $display("test override done");
      give_verdict();
   end
endmodule // startup_strap_config_decoder_test
